//--- hpc_pkg.sv
// constants shared by the host port control and status logic
package hpc_pkg;

    // ------------------------------------------------------------
    // host register addresses (host address bits 2..0)
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL     = 3'h0;
    localparam logic [2:0] ADDR_STAT     = 3'h2;
    localparam logic [2:0] ADDR_BYTE_HI  = 3'h6;
    localparam logic [2:0] ADDR_BYTE_LO  = 3'h7;

    // ------------------------------------------------------------
    // host_side_control field positions
    // ------------------------------------------------------------
    localparam int CB_RX_EN    = 0;
    localparam int CB_TX_EN    = 1;
    localparam int CB_FLAG0    = 3;
    localparam int CB_FLAG1    = 4;
    localparam int CB_MODE_LO  = 5;
    localparam int CB_INIT     = 7;

    // ------------------------------------------------------------
    // host_side_status field positions
    // ------------------------------------------------------------
    localparam int SB_RX_FULL  = 0;
    localparam int SB_TX_EMPTY = 1;
    localparam int SB_TX_CLEAR = 2;
    localparam int SB_FLAG2    = 3;
    localparam int SB_FLAG3    = 4;
    localparam int SB_DMA      = 6;
    localparam int SB_REQ      = 7;

    // ------------------------------------------------------------
    // transfer modes and counter values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_INT     = 2'h0;
    localparam logic [1:0] MODE_ILLEGAL = 2'h1;
    localparam logic [1:0] MODE_DMA16   = 2'h2;
    localparam logic [1:0] MODE_DMA8    = 2'h3;
    localparam logic [1:0] CNT_LAST     = 2'h3;
    localparam logic [1:0] CNT_RST      = 2'h0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic       RX_FULL_RST  = 1'b0;
    localparam logic       TX_EMPTY_RST = 1'b1;
    localparam logic       TX_CLEAR_RST = 1'b1;

endpackage

//--- hpc_if.sv
// event and status bundle between the port control and its status flags
`timescale 1ns/100ps
`default_nettype none
interface hpc_flag_if;
    logic rx_fill;      // dsp word moved into receive byte pair
    logic rx_drain;     // host read low receive byte
    logic tx_fill;      // host wrote low transmit byte
    logic tx_drain;     // transmit pair moved to dsp
    logic init_rx;      // initialize clears receive channel
    logic init_tx;      // initialize clears transmit channel
    logic dsp_rx_full;  // dsp receive register holds data
    logic rx_full;
    logic tx_empty;
    logic tx_clear;

    modport ctl (output rx_fill, rx_drain, tx_fill, tx_drain, init_rx, init_tx,
                 dsp_rx_full, input rx_full, tx_empty, tx_clear);
    modport flg (input rx_fill, rx_drain, tx_fill, tx_drain, init_rx, init_tx,
                 dsp_rx_full, output rx_full, tx_empty, tx_clear);
endinterface
`default_nettype wire

//--- hpc_dma_cnt.sv
// two-bit dma register address counter with circular reload
`timescale 1ns/100ps
`default_nettype none
module hpc_dma_cnt (
    input  wire logic       i_clk,   // system clock
    input  wire logic       i_rst,   // sync reset, active high
    input  wire logic       i_load,  // preload from mode field
    input  wire logic       i_step,  // one dma bus transfer done
    input  wire logic [1:0] i_mode,  // transfer-mode field
    output logic      [1:0] o_cnt    // selected byte register
);
    typedef struct packed {
        logic [1:0] cnt;
    } hpc_cnt_st_t;

    hpc_cnt_st_t s_q;
    hpc_cnt_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (i_load)
        begin
            s_d.cnt = i_mode;
        end
        else if (i_step)
        begin
            // low byte reached: reload so transfers run circularly
            if (s_q.cnt == hpc_pkg::CNT_LAST)
            begin
                s_d.cnt = i_mode;
            end
            else
            begin
                s_d.cnt = s_q.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q.cnt <= hpc_pkg::CNT_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_cnt = s_q.cnt;
endmodule
`default_nettype wire

//--- hpc_flags.sv
// receive-full, transmit-empty and transmitter-ready status flags
`timescale 1ns/100ps
`default_nettype none
module hpc_flags (
    input  wire logic i_clk,  // system clock
    input  wire logic i_rst,  // sync reset, active high
    hpc_flag_if.flg   f       // events in, status out
);
    typedef struct packed {
        logic rx_full;
        logic tx_empty;
        logic tx_clear;
    } hpc_flg_st_t;

    hpc_flg_st_t s_q;
    hpc_flg_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        // clears first, so a set in the same cycle wins
        if (f.rx_drain || f.init_rx)
        begin
            s_d.rx_full = 1'b0;
        end
        if (f.rx_fill)
        begin
            s_d.rx_full = 1'b1;
        end
        if (f.tx_fill)
        begin
            s_d.tx_empty = 1'b0;
        end
        if (f.tx_drain || f.init_tx)
        begin
            s_d.tx_empty = 1'b1;
        end
        s_d.tx_clear = s_d.tx_empty & ~f.dsp_rx_full;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q.rx_full  <= hpc_pkg::RX_FULL_RST;
            s_q.tx_empty <= hpc_pkg::TX_EMPTY_RST;
            s_q.tx_clear <= hpc_pkg::TX_CLEAR_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign f.rx_full  = s_q.rx_full;
    assign f.tx_empty = s_q.tx_empty;
    assign f.tx_clear = s_q.tx_clear;
endmodule
`default_nettype wire

//--- hpc_port_ctl.sv
// host port control/status: control register, status, dma addressing
`timescale 1ns/100ps
`default_nettype none
// How it works
// - host flags zero/one: host writes, dsp sees
// - mode field: interrupt, illegal, dma16, dma8
// - dma mode: request/ack serve dma only
// - interrupt mode: enables gate request, ack ignored
// - dma out: selected receive byte driven on ack
// - dma in: bus written to transmit byte on ack
// - two-bit counter, preloaded from mode, addresses bytes
// - dma forces address bit two high
// - counter steps; at low byte reloads from mode
// - host sets initialize; hardware clears when done
// - initialize loads counter, clears channels by enables
// - interrupt-mode initialize: counter zero, channel clears
// - dma initialize: counter loaded from mode, same channel clears; both enables set illegal
// - receive-full: set on fill, cleared by read
// - transmit-empty: set on drain, cleared by write
// - enables gate request; status always pollable
// - transmitter-ready: tx empty and dsp rx clear
// - status flags two/three follow dsp, reset clear
// - status register at address two, fixed layout
// - reset clears mode, initialize, host flags
// - dma direction: rx enable out, tx enable in
// - control register at address zero, fixed layout
// - status bit seven mirrors request output
// - status bit six shows dma mode
module hpc_port_ctl (
    input  wire logic        i_clk,              // system clock, 20 MHz
    input  wire logic        i_rst,              // sync reset, active high
    input  wire logic [2:0]  i_hst_addr,         // host address bits 2..0
    input  wire logic        i_hst_rw,           // 1 read, 0 write
    input  wire logic        i_hst_en,           // host access strobe
    input  wire logic [7:0]  i_hst_data,         // host data bus in
    output logic      [7:0]  o_hst_data,         // host data bus out
    output logic             o_hst_data_oe,      // drive host data bus
    input  wire logic        i_host_ack_in,      // acknowledge, high active
    output logic             o_host_request_out, // request, high active
    input  wire logic        i_rx_load,          // dsp word into receive pair
    input  wire logic [15:0] i_rx_word,          // word for receive pair
    input  wire logic        i_tx_unload,        // dsp took transmit pair
    input  wire logic        i_dsp_rx_full,      // dsp receive register full
    input  wire logic        i_dsp_flag_two,     // dsp control flag two
    input  wire logic        i_dsp_flag_three,   // dsp control flag three
    output logic      [15:0] o_tx_pair,          // transmit byte pair
    output logic             o_host_flag_zero,   // host flag zero to dsp
    output logic             o_host_flag_one,    // host flag one to dsp
    output logic             o_dsp_tx_empty_set, // pulse: set dsp tx empty
    output logic             o_dsp_rx_clear,     // pulse: clear dsp rx full
    output logic             o_dma_mode          // dma mode active
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rx_en;
        logic       tx_en;
        logic       flag0;
        logic       flag1;
        logic [1:0] mode;
        logic       init;
        logic       en_prev;
        logic       ack_prev;
        logic [7:0] rdata;
        logic       oe;
        logic       req;
        logic       dma_st;
        logic       flag2;
        logic       flag3;
        logic [7:0] tx_hi;
        logic [7:0] tx_lo;
        logic [7:0] rx_hi;
        logic [7:0] rx_lo;
        logic       pls_txe;
        logic       pls_rxc;
    } hpc_top_st_t;

    hpc_top_st_t s_q;
    hpc_top_st_t s_d;

    hpc_flag_if  flg ();
    logic [1:0]  cnt;
    logic        dma_on;
    logic        host_acc;
    logic        dma_xfer;
    logic        rd;
    logic        wr;
    logic [2:0]  addr;
    logic        wr_ctrl;
    logic [7:0]  ctrl_byte;
    logic [7:0]  stat_byte;
    logic [7:0]  rd_mux;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    hpc_dma_cnt u_cnt (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_load (s_q.init),
        .i_step (dma_xfer),
        .i_mode (s_q.mode),
        .o_cnt  (cnt)
    );

    hpc_flags u_flags (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .f     (flg.flg)
    );

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    always_comb
    begin
        dma_on   = (s_q.mode != hpc_pkg::MODE_INT);
        // ack rising edge is one dma bus transfer; both enables set moves nothing
        dma_xfer = dma_on & i_host_ack_in & ~s_q.ack_prev
                 & (s_q.rx_en ^ s_q.tx_en);
        // host access on strobe edge; a colliding dma transfer wins
        host_acc = i_hst_en & ~s_q.en_prev & ~dma_xfer;
        // counter replaces low address bits, bit two forced high
        addr     = dma_xfer ? {1'b1, cnt} : i_hst_addr;
        rd       = (host_acc & i_hst_rw) | (dma_xfer & s_q.rx_en);
        wr       = (host_acc & ~i_hst_rw) | (dma_xfer & s_q.tx_en);
        wr_ctrl  = wr & (addr == hpc_pkg::ADDR_CTRL);
    end

    // ------------------------------------------------------------
    // register images
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_byte                         = 8'h00;
        ctrl_byte[hpc_pkg::CB_RX_EN]      = s_q.rx_en;
        ctrl_byte[hpc_pkg::CB_TX_EN]      = s_q.tx_en;
        ctrl_byte[hpc_pkg::CB_FLAG0]      = s_q.flag0;
        ctrl_byte[hpc_pkg::CB_FLAG1]      = s_q.flag1;
        ctrl_byte[hpc_pkg::CB_MODE_LO+:2] = s_q.mode;
        ctrl_byte[hpc_pkg::CB_INIT]       = s_q.init;

        stat_byte                         = 8'h00;
        stat_byte[hpc_pkg::SB_RX_FULL]    = flg.rx_full;
        stat_byte[hpc_pkg::SB_TX_EMPTY]   = flg.tx_empty;
        stat_byte[hpc_pkg::SB_TX_CLEAR]   = flg.tx_clear;
        stat_byte[hpc_pkg::SB_FLAG2]      = s_q.flag2;
        stat_byte[hpc_pkg::SB_FLAG3]      = s_q.flag3;
        stat_byte[hpc_pkg::SB_DMA]        = s_q.dma_st;
        stat_byte[hpc_pkg::SB_REQ]        = s_q.req;

        unique case (addr)
            hpc_pkg::ADDR_CTRL:    rd_mux = ctrl_byte;
            hpc_pkg::ADDR_STAT:    rd_mux = stat_byte;
            hpc_pkg::ADDR_BYTE_HI: rd_mux = s_q.rx_hi;
            hpc_pkg::ADDR_BYTE_LO: rd_mux = s_q.rx_lo;
            default:               rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // flag events
    // ------------------------------------------------------------
    assign flg.rx_fill     = i_rx_load;
    assign flg.rx_drain    = rd & (addr == hpc_pkg::ADDR_BYTE_LO);
    assign flg.tx_fill     = wr & (addr == hpc_pkg::ADDR_BYTE_LO);
    assign flg.tx_drain    = i_tx_unload;
    assign flg.init_rx     = s_q.init & s_q.rx_en;
    assign flg.init_tx     = s_q.init & s_q.tx_en;
    assign flg.dsp_rx_full = i_dsp_rx_full;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d          = s_q;
        s_d.en_prev  = i_hst_en;
        s_d.ack_prev = i_host_ack_in;
        s_d.flag2    = i_dsp_flag_two;
        s_d.flag3    = i_dsp_flag_three;
        // command completes in one cycle, then the bit drops itself
        s_d.init     = 1'b0;
        s_d.pls_txe  = flg.init_rx;
        s_d.pls_rxc  = flg.init_tx;
        if (wr_ctrl)
        begin
            s_d.rx_en = i_hst_data[hpc_pkg::CB_RX_EN];
            s_d.tx_en = i_hst_data[hpc_pkg::CB_TX_EN];
            s_d.flag0 = i_hst_data[hpc_pkg::CB_FLAG0];
            s_d.flag1 = i_hst_data[hpc_pkg::CB_FLAG1];
            s_d.mode  = i_hst_data[hpc_pkg::CB_MODE_LO+:2];
            s_d.init  = i_hst_data[hpc_pkg::CB_INIT];
        end
        if (wr & (addr == hpc_pkg::ADDR_BYTE_HI))
        begin
            s_d.tx_hi = i_hst_data;
        end
        if (flg.tx_fill)
        begin
            s_d.tx_lo = i_hst_data;
        end
        if (i_rx_load)
        begin
            s_d.rx_hi = i_rx_word[15:8];
            s_d.rx_lo = i_rx_word[7:0];
        end
        if (rd)
        begin
            s_d.rdata = rd_mux;
        end
        // keep driving while the strobe or the dma ack is held
        s_d.oe = rd | (s_q.oe & ((i_hst_en & i_hst_rw)
                              | (dma_on & s_q.rx_en & i_host_ack_in)));
        // in dma the request drops while a transfer is acknowledged
        s_d.req = ((s_q.rx_en & flg.rx_full) | (s_q.tx_en & flg.tx_empty))
                & ~(dma_on & i_host_ack_in);
        s_d.dma_st = (s_d.mode != hpc_pkg::MODE_INT);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q          <= '0;
            s_q.rx_en    <= hpc_pkg::CTRL_RST[hpc_pkg::CB_RX_EN];
            s_q.tx_en    <= hpc_pkg::CTRL_RST[hpc_pkg::CB_TX_EN];
            s_q.flag0    <= hpc_pkg::CTRL_RST[hpc_pkg::CB_FLAG0];
            s_q.flag1    <= hpc_pkg::CTRL_RST[hpc_pkg::CB_FLAG1];
            s_q.mode     <= hpc_pkg::MODE_INT;
            s_q.init     <= hpc_pkg::CTRL_RST[hpc_pkg::CB_INIT];
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_hst_data         = s_q.rdata;
    assign o_hst_data_oe      = s_q.oe;
    assign o_host_request_out = s_q.req;
    assign o_tx_pair          = {s_q.tx_hi, s_q.tx_lo};
    assign o_host_flag_zero   = s_q.flag0;
    assign o_host_flag_one    = s_q.flag1;
    assign o_dsp_tx_empty_set = s_q.pls_txe;
    assign o_dsp_rx_clear     = s_q.pls_rxc;
    assign o_dma_mode         = s_q.dma_st;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_flag_mirror:
    assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ctrl |=> (o_host_flag_zero == $past(i_hst_data[3]))
                 && (o_host_flag_one == $past(i_hst_data[4])))
        else $error("host flag write not mirrored");

    a_init_self_clear:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (s_q.init && !wr_ctrl) |=> !s_q.init)
        else $error("initialize bit not cleared after command");

    a_init_load_cnt:
    assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.init |=> (cnt == $past(s_q.mode)))
        else $error("initialize did not preload counter");

    a_init_clear_rx:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (s_q.init && s_q.rx_en && !i_rx_load) |=> !flg.rx_full && o_dsp_tx_empty_set)
        else $error("initialize did not clear receive channel");

    a_cnt_step_wrap:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (dma_xfer && !s_q.init) |=> (cnt == (($past(cnt) == 2'h3) ? $past(s_q.mode)
                                             : $past(cnt) + 2'h1)))
        else $error("dma counter step or reload wrong");

    a_dma_tx_low:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (dma_xfer && s_q.tx_en && cnt == 2'h3) |=> (o_tx_pair[7:0] == $past(i_hst_data))
                                                 && !flg.tx_empty || $past(i_tx_unload))
        else $error("dma write missed low transmit byte");

    a_dma_rx_drive:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (dma_xfer && s_q.rx_en) ##1 (i_host_ack_in && s_q.mode != 2'h0) |-> o_hst_data_oe)
        else $error("dma read not driven on bus");

    a_rx_full_set:
    assert property (@(posedge i_clk) disable iff (i_rst)
        i_rx_load |=> flg.rx_full ##0 (stat_byte[0] == 1'b1))
        else $error("receive-full not set on fill");

    a_req_gated:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (!s_q.rx_en && !s_q.tx_en) |=> !o_host_request_out)
        else $error("request asserted with enables off");

    a_dma_status:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_dma_mode == (s_q.mode != 2'h0))
        else $error("dma status disagrees with mode");

    a_status_read:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (rd && addr == 3'h2) |=> (o_hst_data[2:0] == $past({flg.tx_clear, flg.tx_empty,
                                                             flg.rx_full}))
                               && (o_hst_data[5] == 1'b0))
        else $error("status read layout wrong");

    a_req_ack_drop:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (dma_on && i_host_ack_in) |=> !o_host_request_out)
        else $error("request held during dma acknowledge");

    a_dma_addr_high:
    assert property (@(posedge i_clk) disable iff (i_rst)
        dma_xfer |-> (addr[2] == 1'b1) && (addr[1:0] == cnt))
        else $error("dma address not forced");

    a_tx_empty_clear:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (flg.tx_fill && !i_tx_unload && !flg.init_tx) |=> !flg.tx_empty)
        else $error("transmit-empty not cleared on low byte write");

    a_tx_ready:
    assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1 |=> flg.tx_clear == (flg.tx_empty && !$past(i_dsp_rx_full)))
        else $error("transmitter-ready disagrees with its sources");

    a_flag_hold:
    assert property (@(posedge i_clk) disable iff (i_rst)
        !wr_ctrl |=> (o_host_flag_zero == $past(o_host_flag_zero))
                  && (o_host_flag_one == $past(o_host_flag_one)))
        else $error("host flag changed without host write");

    a_dsp_flag_follow:
    assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1 |=> (s_q.flag2 == $past(i_dsp_flag_two))
              && (s_q.flag3 == $past(i_dsp_flag_three)))
        else $error("dsp flags not mirrored");
endmodule
`default_nettype wire

//--- hpc_dma_model.sv
// dma controller model that answers the port's request line
`timescale 1ns/100ps
`default_nettype none
module hpc_dma_model (
    input  wire logic       i_clk, // system clock
    input  wire logic       i_go,  // channel armed
    input  wire logic       i_req, // request from port
    input  wire logic [7:0] i_wr,  // base byte to send
    output logic            o_ack, // acknowledge
    output logic      [7:0] o_dat  // bus byte
);
    logic [7:0] n    = 8'h00;
    logic [1:0] hold = 2'h0;
    initial o_ack = 1'b0;
    initial o_dat = 8'h00;
    always @(posedge i_clk)
    begin
        #5;
        if (hold != 2'h0)
        begin
            hold = hold - 2'h1;
            if (hold == 2'h0)
            begin
                o_ack = 1'b0; // ack held two edges, then idle
                o_dat = ~o_dat; // released bus must not keep the byte
            end
        end
        else if (i_go && i_req && ($urandom_range(1, 0) == 1))
        begin
            o_dat = i_wr + n;
            n = n + 8'h01;
            hold = 2'h2;
            o_ack = 1'b1; // acks only answer a request, random stalls
        end
    end
endmodule
`default_nettype wire

//--- hpc_port_ctl_test.sv
// self-checking bench for the host port control and status block
`timescale 1ns/100ps
`default_nettype none
module hpc_port_ctl_test;
    logic        clk = 1'b0, rst = 1'b1, en = 1'b0, rw = 1'b1, go = 1'b0;
    logic        rx_byte_low = 1'b0, txu = 1'b0, drf = 1'b0, f2 = 1'b0, f3 = 1'b0;
    logic        rxf = 1'b0, txe = 1'b1, ack, req, fz, fo;
    logic        oe, dm, pts, prc;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wd = 8'h00, dw = 8'h00, c = 8'h00, v, hd, dd;
    logic [15:0] rxw = 16'h0000, txp;
    int          bad_count = 0, n_checks = 0;
    wire  [7:0]  bus = ack ? dd : wd;
    hpc_port_ctl dut_u (
        .i_clk(clk), .i_rst(rst), .i_hst_addr(addr), .i_hst_rw(rw), .i_hst_en(en),
        .i_hst_data(bus), .o_hst_data(hd), .o_hst_data_oe(oe), .i_host_ack_in(ack),
        .o_host_request_out(req), .i_rx_load(rx_byte_low), .i_rx_word(rxw), .i_tx_unload(txu),
        .i_dsp_rx_full(drf), .i_dsp_flag_two(f2), .i_dsp_flag_three(f3), .o_tx_pair(txp),
        .o_host_flag_zero(fz), .o_host_flag_one(fo), .o_dsp_tx_empty_set(pts),
        .o_dsp_rx_clear(prc), .o_dma_mode(dm)
    );
    hpc_dma_model dma_u (.i_clk(clk), .i_go(go), .i_req(req), .i_wr(dw), .o_ack(ack), .o_dat(dd));
    initial forever #25 clk = ~clk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] stat_exp();
        return {(c[0] & rxf) | (c[1] & txe), |c[6:5], 1'b0, f3, f2, txe & ~drf, txe, rxf};
    endfunction
    task automatic tick();
        @(posedge clk);
        #5;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobe held across one edge only, so each call is a single access
    task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
        tick();
        en = 1'b1;
        rw = r;
        addr = a;
        wd = d;
        tick();
        chk(oe, r);
        en = 1'b0;
        tick();
    endtask
    task automatic load_rx();
        tick();
        rx_byte_low = 1'b1;
        tick();
        rx_byte_low = 1'b0;
        rxf = 1'b1;
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #(50 * 3000);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(32'hB9BF));
        repeat (4) tick();
        rst = 1'b0;
        acc(1'b1, hpc_pkg::ADDR_STAT, 8'h00);
        chk(hd, stat_exp());
        acc(1'b1, hpc_pkg::ADDR_CTRL, 8'h00);
        chk(hd, c);
        repeat (4)
        begin
            v = 8'($urandom()) & 8'h1B;
            {f3, f2} = 2'($urandom());
            acc(1'b0, hpc_pkg::ADDR_CTRL, v);
            c = v;
            acc(1'b0, hpc_pkg::ADDR_STAT, 8'hFF);
            acc(1'b1, hpc_pkg::ADDR_CTRL, 8'h00);
            chk(hd, c);
            chk({fo, fz}, c[4:3]);
            acc(1'b1, hpc_pkg::ADDR_STAT, 8'h00);
            chk(hd, stat_exp());
            chk(req, stat_exp() >> 7);
            chk(dm, |c[6:5]);
        end
        acc(1'b1, 3'h1, 8'h00);
        chk(hd, 8'h00);
        acc(1'b0, hpc_pkg::ADDR_CTRL, 8'h00);
        c = 8'h00;
        rxw = 16'($urandom());
        load_rx();
        tick();
        chk(req, 1'b0);
        acc(1'b1, hpc_pkg::ADDR_STAT, 8'h00);
        chk(hd, stat_exp());
        acc(1'b0, hpc_pkg::ADDR_CTRL, 8'h01);
        c = 8'h01;
        tick();
        chk(req, 1'b1);
        acc(1'b1, hpc_pkg::ADDR_BYTE_HI, 8'h00);
        chk(hd, rxw[15:8]);
        acc(1'b1, hpc_pkg::ADDR_BYTE_LO, 8'h00);
        rxf = 1'b0;
        chk(hd, rxw[7:0]);
        acc(1'b1, hpc_pkg::ADDR_STAT, 8'h00);
        chk(hd, stat_exp());
        v = 8'($urandom());
        acc(1'b0, hpc_pkg::ADDR_BYTE_HI, ~v);
        acc(1'b0, hpc_pkg::ADDR_BYTE_LO, v);
        txe = 1'b0;
        chk(txp, {~v, v});
        drf = 1'b1;
        tick();
        txu = 1'b1;
        tick();
        txu = 1'b0;
        txe = 1'b1;
        acc(1'b1, hpc_pkg::ADDR_STAT, 8'h00);
        chk(hd, stat_exp());
        drf = 1'b0;
        load_rx();
        acc(1'b0, hpc_pkg::ADDR_BYTE_LO, v);
        acc(1'b0, hpc_pkg::ADDR_CTRL, 8'h83);
        chk({pts, prc}, 2'b11);
        c = 8'h03;
        rxf = 1'b0;
        acc(1'b1, hpc_pkg::ADDR_CTRL, 8'h00);
        chk(hd, c);
        acc(1'b1, hpc_pkg::ADDR_STAT, 8'h00);
        chk(hd, stat_exp());
        acc(1'b0, hpc_pkg::ADDR_CTRL, 8'hC2);
        chk({pts, prc}, 2'b01);
        c = 8'h42;
        dw = 8'($urandom());
        go = 1'b1;
        repeat (40) tick();
        go = 1'b0;
        txe = 1'b0;
        chk(txp, {dw, dw + 8'h01});
        acc(1'b1, hpc_pkg::ADDR_STAT, 8'h00);
        chk(hd, stat_exp());
        chk(dm, |c[6:5]);
        acc(1'b0, hpc_pkg::ADDR_CTRL, 8'hE2);
        c = 8'h62;
        v = dw;
        dw = 8'($urandom());
        go = 1'b1;
        repeat (40) tick();
        go = 1'b0;
        chk(txp, {v, dw + 8'h02});
        acc(1'b1, hpc_pkg::ADDR_CTRL, 8'h00);
        chk(hd, c);
        // dsp-to-host dma: one low byte read in 8-bit mode
        acc(1'b0, hpc_pkg::ADDR_CTRL, 8'hE1);
        c = 8'h61;
        chk({pts, prc}, 2'b10);
        rxw = 16'($urandom());
        load_rx();
        go = 1'b1;
        repeat (20) tick();
        go = 1'b0;
        rxf = 1'b0;
        chk(hd, rxw[7:0]);
        acc(1'b1, hpc_pkg::ADDR_STAT, 8'h00);
        chk(hd, stat_exp());
        print_verdict();
    end
endmodule
`default_nettype wire
